// ### hdl/pmc_pkg.sv
package pmc_pkg;
    // Register bus widths
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [8:0] OFS_SUPPLY_EVT = 9'h007;
    localparam logic [8:0] OFS_INPUT_EVT = 9'h008;
    localparam logic [8:0] OFS_MASK_SYS = 9'h00A;
    localparam logic [8:0] OFS_MASK_SUPPLY = 9'h00B;
    localparam logic [8:0] OFS_MASK_INPUT = 9'h00C;
    localparam logic [8:0] OFS_PWR_CTRL = 9'h00E;
    localparam logic [8:0] OFS_START_CFG = 9'h00F;

    // Implemented bits of each register, reserved bits read zero
    localparam logic [7:0] SUPPLY_EVT_BITS = 8'hAA;
    localparam logic [7:0] INPUT_EVT_BITS = 8'h1F;
    localparam logic [7:0] MASK_SYS_BITS = 8'h1F;

    // Supply event positions
    localparam int SUP_VDD_WARN = 7;
    localparam int SUP_RAMP_DONE = 5;
    localparam int SUP_REG_OC = 3;
    localparam int SUP_TEMP_WARN = 1;

    // Power domain control fields
    localparam int PWR_TGT_LSB = 0;
    localparam int PWR_SYS_TGT = 0;
    localparam int PWR_STANDBY = 3;
    localparam int PWR_WMASK_LSB = 4;
    localparam int PWR_DOMAINS = 3;

    // Start-up and watchdog configuration fields
    localparam int CFG_SOFT_START = 7;
    localparam int CFG_TRIAL_MSB = 6;
    localparam int CFG_TRIAL_LSB = 5;
    localparam int CFG_KEY_LOCK = 4;
    localparam int CFG_RST_SELECT = 3;
    localparam int CFG_LIMIT_EN = 2;
    localparam int CFG_WDOG_PD = 1;

    // Reset values and the restart trial count maximum
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PWR_CTRL_RST = 8'h01;
    localparam logic [7:0] START_CFG_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [1:0] TRIAL_RST = 2'h0;
    localparam logic [1:0] TRIAL_MAX = 2'h3;

    // Register access request from the serial interface engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pmc_req_t;

    // Power-down request towards the sequencer
    typedef struct packed {
        logic req;
        logic partial;
    } pmc_pd_t;
endpackage : pmc_pkg

// ### hdl/pmc_evt_latch.sv
`timescale 1ns/1ns
module pmc_evt_latch #(
    parameter logic [7:0] BITS = 8'hFF
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [7:0] set_pulse, // Event pulses
    input wire logic clr_wr, // Write to this register
    input wire logic [7:0] clr_data, // Written value, ones clear
    output logic [7:0] flags_ff // Latched flags
);
    logic [7:0] nxt_flags;

    // Hold flags until written back; a new event wins over its clear
    always_comb begin
        nxt_flags = flags_ff;
        if (clr_wr) begin
            nxt_flags = nxt_flags & ~clr_data;
        end
        nxt_flags = (nxt_flags | set_pulse) & BITS;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags_ff <= 8'h00;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // New events land even under a clear; idle flags hold
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    set_wins_a: assert property ((set_pulse & BITS) != 8'h00
        |=> (flags_ff & $past(set_pulse & BITS)) == $past(set_pulse & BITS))
        else $error("Event lost on clear");
    flag_hold_a: assert property (!clr_wr && set_pulse == 8'h00
        |=> flags_ff == $past(flags_ff))
        else $error("Flag changed without cause");
endmodule : pmc_evt_latch

// ### hdl/pmc_regs.sv
`timescale 1ns/1ns
// Function
// - Supply events latch at bits 7, 5, 3 and 1; other bits reserved.
// - Flags stay set until host writes back the value it read.
// - Input events 0..4 latch at bits 0..4, each with a mask bit.
// - System mask register holds five masks at bits 4..0.
// - Supply mask register holds masks at the supply event positions.
// - Control bits 2..0 hold secondary, main and system domain targets.
// - Control bits 6..4 gate the write of each domain target.
// - Power-down on system target clear, enable release or long key press; bit 3 depth.
// - Configuration bit 7 enables converter soft start.
// - Bits 6:5 hold the restart trial count that blocks wakeups.
// - Restart limit acts only while configuration bit 2 is set.
// - Bit 4 selects normal power-down or key-delay governed power-down.
// - Bit 3 selects whether reset output asserts during power-down.
// - Bit 1 keeps watchdog running in power-down when set.
// - Summary bits show any supply and any input event active.
module pmc_regs (
    input wire logic sys_clk, // 125 MHz system clock
    input wire logic rst, // Synchronous reset, active high
    input wire pmc_pkg::pmc_req_t req, // Register request from serial engine
    output logic [7:0] rdata_ff, // Read data
    output logic rvalid_ff, // Read data valid pulse
    input wire logic [7:0] supply_evt, // Supply event pulses
    input wire logic [4:0] input_evt, // Input event pulses
    input wire logic [4:0] sys_evt_flags, // Flags of the system event register
    input wire logic system_enable_input, // System enable pin level
    input wire logic key_long_press, // Long press pulse from key logic
    input wire logic in_powerdown, // Sequencer is in power-down
    input wire logic wdog_restart, // Watchdog restart trial pulse
    output logic irq_ff, // Interrupt request, active high
    output logic supply_events_active, // Summary of supply events
    output logic input_events_active, // Summary of input events
    output logic [2:0] domain_target, // Secondary, main, system targets
    output pmc_pkg::pmc_pd_t pd_ff, // Power-down request and depth
    output logic converter_soft_start, // Buck soft start enable
    output logic key_lock_select, // Power-down governed by key delay
    output logic reset_output_n_ff, // Reset output pin, active low
    output logic watchdog_enable_ff, // Watchdog timer may run
    output logic wakeup_block_ff // All wakeups blocked
);
    logic [7:0] supply_flags;
    logic [7:0] input_flags;
    logic [7:0] mask_sys_ff;
    logic [7:0] mask_supply_ff;
    logic [7:0] mask_input_ff;
    logic [7:0] pwr_ctrl_ff;
    logic [7:0] start_cfg_ff;
    logic [7:0] nxt_mask_sys;
    logic [7:0] nxt_mask_supply;
    logic [7:0] nxt_mask_input;
    logic [7:0] nxt_pwr_ctrl;
    logic [7:0] nxt_start_cfg;
    logic [7:0] nxt_rdata;
    logic nxt_rvalid;
    logic wr_supply;
    logic wr_input;
    logic sysen_s1_ff;
    logic sysen_s2_ff;
    logic sysen_prev_ff;
    logic sys_tgt_clear;
    logic sysen_release;
    logic pd_trigger;
    pmc_pkg::pmc_pd_t nxt_pd;
    logic nxt_irq;
    logic nxt_reset_n;
    logic nxt_wdog_en;
    logic [1:0] trial_ff;
    logic [1:0] nxt_trial;
    logic nxt_block;

    assign wr_supply = req.wr && req.addr == pmc_pkg::OFS_SUPPLY_EVT;
    assign wr_input = req.wr && req.addr == pmc_pkg::OFS_INPUT_EVT;

    // Supply event flags
    pmc_evt_latch #(
        .BITS(pmc_pkg::SUPPLY_EVT_BITS)
    ) u_supply_evt (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_pulse(supply_evt),
        .clr_wr(wr_supply),
        .clr_data(req.wdata),
        .flags_ff(supply_flags)
    );

    // Input event flags
    pmc_evt_latch #(
        .BITS(pmc_pkg::INPUT_EVT_BITS)
    ) u_input_evt (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_pulse({3'h0, input_evt}),
        .clr_wr(wr_input),
        .clr_data(req.wdata),
        .flags_ff(input_flags)
    );

    // Summary bits for the supply and input event registers
    assign supply_events_active = supply_flags != 8'h00;
    assign input_events_active = input_flags != 8'h00;

    // Register writes; domain targets only change where the written mask bit is set
    always_comb begin
        nxt_mask_sys = mask_sys_ff;
        nxt_mask_supply = mask_supply_ff;
        nxt_mask_input = mask_input_ff;
        nxt_pwr_ctrl = pwr_ctrl_ff;
        nxt_start_cfg = start_cfg_ff;
        if (req.wr) begin
            case (req.addr)
                pmc_pkg::OFS_MASK_SYS: begin
                    nxt_mask_sys = req.wdata & pmc_pkg::MASK_SYS_BITS;
                end
                pmc_pkg::OFS_MASK_SUPPLY: begin
                    nxt_mask_supply = req.wdata & pmc_pkg::SUPPLY_EVT_BITS;
                end
                pmc_pkg::OFS_MASK_INPUT: begin
                    nxt_mask_input = req.wdata & pmc_pkg::INPUT_EVT_BITS;
                end
                pmc_pkg::OFS_PWR_CTRL: begin
                    for (int i = 0; i < pmc_pkg::PWR_DOMAINS; i++) begin
                        if (req.wdata[pmc_pkg::PWR_WMASK_LSB + i]) begin
                            nxt_pwr_ctrl[pmc_pkg::PWR_TGT_LSB + i] =
                                req.wdata[pmc_pkg::PWR_TGT_LSB + i];
                        end
                    end
                    nxt_pwr_ctrl[7:pmc_pkg::PWR_STANDBY] = req.wdata[7:pmc_pkg::PWR_STANDBY];
                end
                pmc_pkg::OFS_START_CFG: begin
                    nxt_start_cfg = req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_sys_ff <= pmc_pkg::MASK_RST;
            mask_supply_ff <= pmc_pkg::MASK_RST;
            mask_input_ff <= pmc_pkg::MASK_RST;
            pwr_ctrl_ff <= pmc_pkg::PWR_CTRL_RST;
            start_cfg_ff <= pmc_pkg::START_CFG_RST;
        end else begin
            mask_sys_ff <= nxt_mask_sys;
            mask_supply_ff <= nxt_mask_supply;
            mask_input_ff <= nxt_mask_input;
            pwr_ctrl_ff <= nxt_pwr_ctrl;
            start_cfg_ff <= nxt_start_cfg;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        nxt_rvalid = req.rd;
        case (req.addr)
            pmc_pkg::OFS_SUPPLY_EVT: nxt_rdata = supply_flags;
            pmc_pkg::OFS_INPUT_EVT: nxt_rdata = input_flags;
            pmc_pkg::OFS_MASK_SYS: nxt_rdata = mask_sys_ff;
            pmc_pkg::OFS_MASK_SUPPLY: nxt_rdata = mask_supply_ff;
            pmc_pkg::OFS_MASK_INPUT: nxt_rdata = mask_input_ff;
            pmc_pkg::OFS_PWR_CTRL: nxt_rdata = pwr_ctrl_ff;
            pmc_pkg::OFS_START_CFG: nxt_rdata = start_cfg_ff;
            default: nxt_rdata = pmc_pkg::RDATA_RST;
        endcase
        if (!req.rd) begin
            nxt_rdata = rdata_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= pmc_pkg::RDATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Unmasked flags drive the interrupt request
    always_comb begin
        nxt_irq = |(supply_flags & ~mask_supply_ff)
            || |(input_flags & ~mask_input_ff)
            || |({3'h0, sys_evt_flags} & ~mask_sys_ff);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // System enable pin synchroniser and release detect
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysen_s1_ff <= 1'b0;
            sysen_s2_ff <= 1'b0;
            sysen_prev_ff <= 1'b0;
        end else begin
            sysen_s1_ff <= system_enable_input;
            sysen_s2_ff <= sysen_s1_ff;
            sysen_prev_ff <= sysen_s2_ff;
        end
    end

    // Power-down triggers and the depth chosen at that moment
    always_comb begin
        sys_tgt_clear = pwr_ctrl_ff[pmc_pkg::PWR_SYS_TGT] && !nxt_pwr_ctrl[pmc_pkg::PWR_SYS_TGT];
        sysen_release = sysen_prev_ff && !sysen_s2_ff;
        pd_trigger = sys_tgt_clear || sysen_release || key_long_press;
        nxt_pd.req = pd_trigger;
        nxt_pd.partial = pd_trigger ? nxt_pwr_ctrl[pmc_pkg::PWR_STANDBY] : pd_ff.partial;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pd_ff <= '0;
        end else begin
            pd_ff <= nxt_pd;
        end
    end

    // Static configuration outputs
    assign domain_target = pwr_ctrl_ff[pmc_pkg::PWR_TGT_LSB +: pmc_pkg::PWR_DOMAINS];
    assign converter_soft_start = start_cfg_ff[pmc_pkg::CFG_SOFT_START];
    assign key_lock_select = start_cfg_ff[pmc_pkg::CFG_KEY_LOCK];

    // Reset pin and watchdog run gating during power-down
    always_comb begin
        nxt_reset_n = !(start_cfg_ff[pmc_pkg::CFG_RST_SELECT] && in_powerdown);
        nxt_wdog_en = !in_powerdown || start_cfg_ff[pmc_pkg::CFG_WDOG_PD];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reset_output_n_ff <= 1'b1;
            watchdog_enable_ff <= 1'b1;
        end else begin
            reset_output_n_ff <= nxt_reset_n;
            watchdog_enable_ff <= nxt_wdog_en;
        end
    end

    // Restart trial counter and wakeup blocking
    always_comb begin
        nxt_trial = trial_ff;
        if (!start_cfg_ff[pmc_pkg::CFG_LIMIT_EN]) begin
            nxt_trial = pmc_pkg::TRIAL_RST;
        end else if (wdog_restart && trial_ff != pmc_pkg::TRIAL_MAX) begin
            nxt_trial = trial_ff + 2'h1;
        end
        nxt_block = start_cfg_ff[pmc_pkg::CFG_LIMIT_EN]
            && nxt_trial >= start_cfg_ff[pmc_pkg::CFG_TRIAL_MSB:pmc_pkg::CFG_TRIAL_LSB];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trial_ff <= pmc_pkg::TRIAL_RST;
            wakeup_block_ff <= 1'b0;
        end else begin
            trial_ff <= nxt_trial;
            wakeup_block_ff <= nxt_block;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Checks and covers of flags, masks, controls and read data
    supply_rsvd_a: assert property ((supply_flags & ~pmc_pkg::SUPPLY_EVT_BITS) == 8'h00)
        else $error("Reserved supply bit set");
    input_latch_a: assert property (input_evt[0] |=> input_flags[0])
        else $error("Input event not latched");
    irq_mask_a: assert property (|(supply_flags & ~mask_supply_ff) |=> irq_ff)
        else $error("Unmasked flag without interrupt");
    input_irq_a: assert property (|(input_flags & ~mask_input_ff) |=> irq_ff)
        else $error("Unmasked input flag without interrupt");
    sys_irq_a: assert property (|({3'h0, sys_evt_flags} & ~mask_sys_ff) |=> irq_ff)
        else $error("Unmasked system flag without interrupt");
    irq_quiet_a: assert property (
        supply_flags == 8'h00 && input_flags == 8'h00 && sys_evt_flags == 5'h00 |=> !irq_ff)
        else $error("Spurious interrupt");
    wmask_gate_a: assert property (
        req.wr && req.addr == pmc_pkg::OFS_PWR_CTRL && !req.wdata[pmc_pkg::PWR_WMASK_LSB + 1]
        |=> domain_target[1] == $past(domain_target[1]))
        else $error("Masked target changed");
    target_wr_a: assert property (
        req.wr && req.addr == pmc_pkg::OFS_PWR_CTRL && req.wdata[pmc_pkg::PWR_WMASK_LSB]
        |=> domain_target[0] == $past(req.wdata[pmc_pkg::PWR_TGT_LSB]))
        else $error("Unmasked target not written");
    sysdn_pd_a: assert property ($fell(domain_target[0])
        |-> pd_ff.req && pd_ff.partial == pwr_ctrl_ff[pmc_pkg::PWR_STANDBY])
        else $error("No power-down on target clear");
    key_pd_a: assert property (key_long_press |=> pd_ff.req)
        else $error("Long press ignored");
    sysen_pd_a: assert property (sysen_prev_ff && !sysen_s2_ff |=> pd_ff.req)
        else $error("Enable release ignored");
    rst_pin_a: assert property (
        in_powerdown && start_cfg_ff[pmc_pkg::CFG_RST_SELECT] |=> !reset_output_n_ff)
        else $error("Reset pin not asserted");
    rst_keep_a: assert property (
        !start_cfg_ff[pmc_pkg::CFG_RST_SELECT] |=> reset_output_n_ff)
        else $error("Reset pin asserted in mode 0");
    wdog_pd_a: assert property (
        in_powerdown && !start_cfg_ff[pmc_pkg::CFG_WDOG_PD] |=> !watchdog_enable_ff)
        else $error("Watchdog not stopped");
    limit_off_a: assert property (
        !start_cfg_ff[pmc_pkg::CFG_LIMIT_EN] |=> !wakeup_block_ff)
        else $error("Block without limit enable");
    summary_a: assert property (
        (supply_evt & pmc_pkg::SUPPLY_EVT_BITS) != 8'h00 |=> supply_events_active)
        else $error("Summary bit wrong");
    input_sum_a: assert property (input_evt != 5'h00 |=> input_events_active)
        else $error("Input summary bit wrong");
    soft_start_a: assert property (req.wr && req.addr == pmc_pkg::OFS_START_CFG
        |=> converter_soft_start == $past(req.wdata[pmc_pkg::CFG_SOFT_START]))
        else $error("Soft start bit not stored");
    read_back_a: assert property (req.rd && req.addr == pmc_pkg::OFS_MASK_SUPPLY && !req.wr
        |=> rvalid_ff && rdata_ff == $past(mask_supply_ff))
        else $error("Bad read data");
    clear_cv: cover property (wr_supply && supply_flags != 8'h00 ##1 supply_flags == 8'h00);
    irq_cv: cover property (!irq_ff ##1 irq_ff);
    pd_cv: cover property (pd_ff.req && pd_ff.partial);
    block_cv: cover property (!wakeup_block_ff ##1 wakeup_block_ff);
    sysen_cv: cover property (sysen_release ##1 pd_ff.req);
endmodule : pmc_regs

// ### tb/pmc_host_model.sv
`timescale 1ns/1ns
// Host on the register port: holds each request over its taking edge
module pmc_host_model (
    input wire logic sys_clk, // System clock
    input wire logic [7:0] rdata_ff, // Read data from the block
    output pmc_pkg::pmc_req_t req // Request to the block
);
    logic [7:0] last_rd; // Value of the latest read
    // Idle until the first access
    initial req = '0;
    // One access for one edge, then released with address and data turned over
    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        req <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge sys_clk);
        #1 req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge sys_clk);
        #1 last_rd = rdata_ff;
    endtask : acc
    // Clear flags by writing back the value just read
    task automatic wb_clear(input logic [8:0] a);
        acc(1'b0, a, 8'h00);
        acc(1'b1, a, last_rd);
    endtask : wb_clear
endmodule : pmc_host_model

// ### tb/test_pmic_event_mask_system_control.sv
`timescale 1ns/1ns
// Bench for the event, mask and system control register bank
module test_pmic_event_mask_system_control;
    logic sys_clk, rst, rvalid_ff, system_enable_input, key_long_press, in_powerdown;
    logic wdog_restart, irq_ff, supply_events_active, input_events_active, pd_part;
    logic converter_soft_start, key_lock_select, reset_output_n_ff, watchdog_enable_ff;
    logic wakeup_block_ff;
    logic [7:0] rdata_ff, supply_evt, v;
    logic [4:0] input_evt, sys_evt_flags;
    logic [2:0] domain_target;
    logic [31:0] xs = 32'h15; // Random state, seed 21
    pmc_pkg::pmc_req_t req;
    pmc_pkg::pmc_pd_t pd_ff;
    logic [7:0] expq[$]; // Expected read data, oldest first
    int bad_count = 0;
    int comparisons = 0;
    int pd_count = 0;
    // Design and host model
    pmc_regs pmc_regs_i (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata_ff(rdata_ff),
        .rvalid_ff(rvalid_ff), .supply_evt(supply_evt), .input_evt(input_evt),
        .sys_evt_flags(sys_evt_flags), .system_enable_input(system_enable_input),
        .key_long_press(key_long_press), .in_powerdown(in_powerdown),
        .wdog_restart(wdog_restart), .irq_ff(irq_ff),
        .supply_events_active(supply_events_active),
        .input_events_active(input_events_active), .domain_target(domain_target),
        .pd_ff(pd_ff), .converter_soft_start(converter_soft_start),
        .key_lock_select(key_lock_select), .reset_output_n_ff(reset_output_n_ff),
        .watchdog_enable_ff(watchdog_enable_ff), .wakeup_block_ff(wakeup_block_ff));
    pmc_host_model pmc_host_model_i (.sys_clk(sys_clk), .rdata_ff(rdata_ff), .req(req));
    // Clock, 8 ns period
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Next xorshift value
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // Wait some edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Read with the expected value noted for the monitor
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        expq.push_back(e);
        pmc_host_model_i.acc(1'b0, a, 8'h00);
    endtask : rd
    // Register write
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        pmc_host_model_i.acc(1'b1, a, d);
    endtask : wr
    // Write-back clear, noting what its read should return
    task automatic clr(input logic [8:0] a, input logic [7:0] e);
        expq.push_back(e);
        pmc_host_model_i.wb_clear(a);
    endtask : clr
    // One-cycle pulses on the event inputs
    task automatic ev(input logic [7:0] s, input logic [4:0] i, input logic k, input logic w);
        supply_evt = s;
        input_evt = i;
        key_long_press = k;
        wdog_restart = w;
        tick(1);
        supply_evt = 8'h00;
        input_evt = 5'h00;
        key_long_press = 1'b0;
        wdog_restart = 1'b0;
        tick(1);
    endtask : ev
    // Take the oldest note when read data appears; count power-down requests
    always @(negedge sys_clk) begin
        if (rvalid_ff === 1'b1) begin
            if (expq.size() == 0) check(8'h00, 8'h01);
            else check(rdata_ff, expq.pop_front());
        end
        if (pd_ff.req === 1'b1) begin
            pd_count++;
            pd_part = pd_ff.partial;
        end
    end
    // Cut a hang short
    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        supply_evt = 8'h00;
        input_evt = 5'h00;
        sys_evt_flags = 5'h00;
        system_enable_input = 1'b0;
        key_long_press = 1'b0;
        in_powerdown = 1'b0;
        wdog_restart = 1'b0;
        tick(6);
        rst = 1'b0;
        // Reset values, unmapped places read zero
        check(8'(domain_target), 8'h01);
        check(8'({reset_output_n_ff, watchdog_enable_ff, wakeup_block_ff, irq_ff}), 8'h0C);
        rd(9'h007, 8'h00);
        rd(9'h008, 8'h00);
        rd(9'h00A, 8'h00);
        rd(9'h00B, 8'h00);
        rd(9'h00C, 8'h00);
        rd(9'h00E, 8'h01);
        rd(9'h00F, 8'h00);
        wr(9'h1FF, 8'hFF);
        rd(9'h1FF, 8'h00);
        // Mask registers keep only their implemented bits
        xs = xorshift(xs);
        wr(9'h00A, xs[7:0]);
        wr(9'h00B, xs[15:8]);
        wr(9'h00C, xs[23:16]);
        rd(9'h00A, xs[7:0] & 8'h1F);
        rd(9'h00B, xs[15:8] & 8'hAA);
        rd(9'h00C, xs[23:16] & 8'h1F);
        wr(9'h00A, 8'h00);
        wr(9'h00B, 8'h00);
        wr(9'h00C, 8'h00);
        // Events latch, raise the request, survive a zero write, clear by write-back
        xs = xorshift(xs);
        v = xs[7:0] | 8'h80;
        ev(v, v[4:0] | 5'h01, 1'b0, 1'b0);
        tick(1);
        check(8'(irq_ff), 8'h01);
        check(8'({supply_events_active, input_events_active}), 8'h03);
        wr(9'h007, 8'h00);
        rd(9'h007, v & 8'hAA);
        clr(9'h007, v & 8'hAA);
        clr(9'h008, v & 8'h1F | 8'h01);
        tick(1);
        check(8'({irq_ff, supply_events_active, input_events_active}), 8'h00);
        rd(9'h007, 8'h00);
        // A set mask holds the request off but lets the flag latch
        wr(9'h00B, 8'hFF);
        wr(9'h00C, 8'hFF);
        ev(8'hAA, 5'h1F, 1'b0, 1'b0);
        tick(1);
        check(8'(irq_ff), 8'h00);
        rd(9'h008, 8'h1F);
        wr(9'h00B, 8'h00);
        tick(1);
        check(8'(irq_ff), 8'h01);
        clr(9'h007, 8'hAA);
        clr(9'h008, 8'h1F);
        wr(9'h00C, 8'h00);
        // System flags reach the request through their own mask
        sys_evt_flags = 5'h04;
        tick(2);
        check(8'(irq_ff), 8'h01);
        wr(9'h00A, 8'h04);
        tick(1);
        check(8'(irq_ff), 8'h00);
        sys_evt_flags = 5'h00;
        // Domain targets move only under their write-mask bits; power-down requests
        wr(9'h00E, 8'h06);
        rd(9'h00E, 8'h01);
        wr(9'h00E, 8'h76);
        check(8'(domain_target), 8'h06);
        rd(9'h00E, 8'h76);
        check(8'({pd_count[1:0], pd_part}), 8'h02);
        wr(9'h00E, 8'h1F);
        ev(8'h00, 5'h00, 1'b1, 1'b0);
        tick(2);
        check(8'({pd_count[1:0], pd_part}), 8'h05);
        rd(9'h00E, 8'h1F);
        system_enable_input = 1'b1;
        tick(4);
        system_enable_input = 1'b0;
        tick(8);
        check(8'({pd_count[1:0], pd_part}), 8'h07);
        // Configuration bits read back and drive their outputs
        xs = xorshift(xs);
        wr(9'h00F, xs[7:0]);
        rd(9'h00F, xs[7:0]);
        check(8'({converter_soft_start, key_lock_select}), 8'({xs[7], xs[4]}));
        // Reset output and watchdog follow the power-down state
        wr(9'h00F, 8'h0A);
        in_powerdown = 1'b1;
        tick(2);
        check(8'({reset_output_n_ff, watchdog_enable_ff}), 8'h01);
        wr(9'h00F, 8'h08);
        tick(1);
        check(8'({reset_output_n_ff, watchdog_enable_ff}), 8'h00);
        in_powerdown = 1'b0;
        tick(2);
        check(8'({reset_output_n_ff, watchdog_enable_ff}), 8'h03);
        wr(9'h00F, 8'h00);
        in_powerdown = 1'b1;
        tick(2);
        check(8'({reset_output_n_ff, watchdog_enable_ff}), 8'h02);
        in_powerdown = 1'b0;
        // Restart trials block wakeups at the limit, only while enabled
        wr(9'h00F, 8'h44);
        ev(8'h00, 5'h00, 1'b0, 1'b1);
        tick(1);
        check(8'(wakeup_block_ff), 8'h00);
        ev(8'h00, 5'h00, 1'b0, 1'b1);
        tick(1);
        check(8'(wakeup_block_ff), 8'h01);
        wr(9'h00F, 8'h40);
        tick(1);
        check(8'(wakeup_block_ff), 8'h00);
        check(8'(expq.size()), 8'h00);
        conclude();
    end
endmodule : test_pmic_event_mask_system_control
